// ### link_station_pkg.sv
// shared constants for the serial link station and format block
package link_station_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_STATION1 = 8'h00;
	localparam logic [7:0] ADDR_STATION2 = 8'h04;
	localparam logic [7:0] ADDR_STATION_TOOL = 8'h08;
	localparam logic [7:0] ADDR_FORMAT = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// ------------------------------------------------------------
	// per-port format field layout, one byte lane per port
	// ------------------------------------------------------------
	localparam int PORT_FIELD_W = 8;
	localparam int FMT_DATA8 = 0;
	localparam int FMT_PAR_LSB = 1;
	localparam int FMT_STOP2 = 3;
	localparam int FMT_BAUD_LSB = 4;
	localparam int FMT_LINK = 7;
	localparam int STAT_SEL_ACTIVE = 16;
	localparam int STAT_RATE_MISMATCH = 17;

	// ------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------
	localparam logic [6:0] STATION_RST = 7'h01;
	localparam logic [6:0] STATION_MIN = 7'h01;
	localparam logic [6:0] STATION_MAX = 7'h63;
	localparam logic [6:0] SEL_HIGH_BASE = 7'h10;
	// 8 data bits, odd parity, 1 stop, 9600 bps, command link
	localparam logic [7:0] FMT_RST = 8'ha3;

	// ------------------------------------------------------------
	// baud selection codes and rates
	// ------------------------------------------------------------
	localparam logic [2:0] BAUD_9600 = 3'h2;
	localparam logic [2:0] BAUD_19200 = 3'h3;
	localparam logic [2:0] BAUD_115200 = 3'h6;
	localparam int unsigned BAUD_TABLE [0:6] = '{2400, 4800, 9600, 19200,
		38400, 57600, 115200};

	// ------------------------------------------------------------
	// frame characters
	// ------------------------------------------------------------
	localparam logic [7:0] CH_HDR_SHORT = 8'h25;
	localparam logic [7:0] CH_HDR_EXT = 8'h3c;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_OK = 8'h24;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A_MINUS10 = 8'h37;
	localparam logic [2:0] RESP_LAST = 3'h6;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ST_HI = 5'b00010,
		S_ST_LO = 5'b00100,
		S_BODY = 5'b01000,
		S_SEND = 5'b10000
	} resp_state_t;

endpackage

// ### link_station.sv
// station selection, format, baud and auto-response for two link ports
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module link_station #(
	parameter int unsigned CLK_HZ = 25000000,
	parameter bit SECOND_IS_DIFF = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [3:0] STATION_DIAL,
	input wire logic STATION_HIGH,
	input wire logic DIFF_RATE_SW,
	input wire logic [15:0] RX_DATA,
	input wire logic [1:0] RX_VALID,
	input wire logic [1:0] TX_READY,
	output logic [15:0] TX_DATA,
	output logic [1:0] TX_VALID,
	output logic [1:0] TX_EN,
	output logic [1:0] BAUD_TICK,
	output logic [1:0] DATA_8BIT,
	output logic [3:0] PARITY_SEL,
	output logic [1:0] STOP_2BIT,
	output logic [6:0] TOOL_STATION
);

	// ------------------------------------------------------------
	// selector pins: three stages, accepted when stages 2 and 3 agree
	// ------------------------------------------------------------
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic [5:0] pin_s3_q;
	logic [5:0] pin_q;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pin_s1_q <= 6'h00;
			pin_s2_q <= 6'h00;
			pin_s3_q <= 6'h00;
			pin_q <= 6'h00;
		end else if (CE) begin
			pin_s1_q <= {DIFF_RATE_SW, STATION_HIGH, STATION_DIAL};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q) begin
				pin_q <= pin_s3_q;
			end
		end
	end

	logic sel_active;
	logic [6:0] sel_station;
	logic rate_sw_fast;

	assign sel_active = pin_q[4] | (pin_q[3:0] != 4'h0);
	assign sel_station = pin_q[4] ? (link_station_pkg::SEL_HIGH_BASE
		+ {3'h0, pin_q[3:0]}) : {3'h0, pin_q[3:0]};
	assign rate_sw_fast = pin_q[5];

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [6:0] station_q [0:2];
	logic [15:0] fmt_q;
	logic [6:0] eff_station [0:1];
	logic rate_mismatch;
	logic wait_q;
	logic req;
	logic [6:0] wr_station;
	logic wr_station_ok;
	logic [2:0] wr_baud2;
	logic wr_baud2_ok;

	// selector number goes to both cassette ports, never the tool port
	assign eff_station[0] = sel_active ? sel_station : station_q[0];
	assign eff_station[1] = sel_active ? sel_station : station_q[1];
	assign TOOL_STATION = station_q[2];

	assign req = AVS_READ | AVS_WRITE;
	assign wr_station = AVS_WRITEDATA[6:0];
	assign wr_station_ok = (wr_station >= link_station_pkg::STATION_MIN)
		&& (wr_station <= link_station_pkg::STATION_MAX)
		&& (AVS_WRITEDATA[7] == 1'b0);
	assign wr_baud2 = AVS_WRITEDATA[14:12];
	// the differential port only knows two rates
	assign wr_baud2_ok = !SECOND_IS_DIFF
		|| (wr_baud2 == link_station_pkg::BAUD_19200)
		|| (wr_baud2 == link_station_pkg::BAUD_115200);
	assign rate_mismatch = SECOND_IS_DIFF && (fmt_q[14:12] != (rate_sw_fast
		? link_station_pkg::BAUD_115200
		: link_station_pkg::BAUD_19200));

	// waitrequest drops for one cycle per request; writes land then
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wait_q <= 1'b1;
		end else if (CE) begin
			wait_q <= !(req && wait_q);
		end
	end
	assign AVS_WAITREQUEST = wait_q;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			station_q[0] <= link_station_pkg::STATION_RST;
			station_q[1] <= link_station_pkg::STATION_RST;
			station_q[2] <= link_station_pkg::STATION_RST;
			fmt_q <= {link_station_pkg::FMT_RST,
				link_station_pkg::FMT_RST};
		end else if (CE && AVS_WRITE && !wait_q) begin
			if (AVS_ADDRESS == link_station_pkg::ADDR_STATION1) begin
				if (AVS_BYTEENABLE[0] && wr_station_ok) begin
					station_q[0] <= wr_station;
				end
			end else if (AVS_ADDRESS == link_station_pkg::ADDR_STATION2) begin
				if (AVS_BYTEENABLE[0] && wr_station_ok) begin
					station_q[1] <= wr_station;
				end
			end else if (AVS_ADDRESS ==
				link_station_pkg::ADDR_STATION_TOOL) begin
				if (AVS_BYTEENABLE[0] && wr_station_ok) begin
					station_q[2] <= wr_station;
				end
			end else if (AVS_ADDRESS == link_station_pkg::ADDR_FORMAT) begin
				if (AVS_BYTEENABLE[0]) begin
					fmt_q[7:0] <= AVS_WRITEDATA[7:0];
				end
				if (AVS_BYTEENABLE[1] && wr_baud2_ok) begin
					fmt_q[15:8] <= AVS_WRITEDATA[15:8];
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (CE && AVS_READ && wait_q) begin
			if (AVS_ADDRESS == link_station_pkg::ADDR_STATION1) begin
				AVS_READDATA <= {25'h0, station_q[0]};
			end else if (AVS_ADDRESS == link_station_pkg::ADDR_STATION2) begin
				AVS_READDATA <= {25'h0, station_q[1]};
			end else if (AVS_ADDRESS ==
				link_station_pkg::ADDR_STATION_TOOL) begin
				AVS_READDATA <= {25'h0, station_q[2]};
			end else if (AVS_ADDRESS == link_station_pkg::ADDR_FORMAT) begin
				AVS_READDATA <= {16'h0, fmt_q};
			end else if (AVS_ADDRESS == link_station_pkg::ADDR_STATUS) begin
				AVS_READDATA <= {14'h0, rate_mismatch, sel_active, 1'b0,
					eff_station[1], 1'b0, eff_station[0]};
			end else begin
				AVS_READDATA <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// per-port format, baud and auto-response
	// ------------------------------------------------------------
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? (link_station_pkg::CH_ZERO + {4'h0, n})
			: (link_station_pkg::CH_A_MINUS10 + {4'h0, n});
	endfunction

	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		int unsigned rate;
		rate = link_station_pkg::BAUD_TABLE[2];
		if (sel <= 3'h6) begin
			rate = link_station_pkg::BAUD_TABLE[sel];
		end
		baud_div = 16'(CLK_HZ / rate - 1);
	endfunction

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [7:0] field;
		logic [15:0] baud_cnt_q;
		logic tick_q;
		link_station_pkg::resp_state_t state_q;
		logic [7:0] hdr_q;
		logic [3:0] digit_hi_q;
		logic [7:0] ch_hi_q;
		logic [7:0] ch_lo_q;
		logic [7:0] bcc_q;
		logic [2:0] idx_q;
		logic [7:0] tx_q;
		logic tx_valid_q;
		logic tx_en_q;
		logic [7:0] rx;
		logic rx_digit;
		logic [6:0] rx_station;
		logic [7:0] next_char;

		assign field = fmt_q[p * link_station_pkg::PORT_FIELD_W +: 8];
		assign DATA_8BIT[p] = field[link_station_pkg::FMT_DATA8];
		assign PARITY_SEL[p * 2 +: 2] =
			field[link_station_pkg::FMT_PAR_LSB +: 2];
		assign STOP_2BIT[p] = field[link_station_pkg::FMT_STOP2];
		assign rx = RX_DATA[p * 8 +: 8];
		assign rx_digit = (rx >= link_station_pkg::CH_ZERO)
			&& (rx <= link_station_pkg::CH_NINE);
		assign rx_station = 7'({digit_hi_q, 3'h0}) + 7'({digit_hi_q, 1'b0})
			+ {3'h0, rx[3:0]};

		always_ff @(posedge REF_CLK or posedge RST) begin
			if (RST) begin
				baud_cnt_q <= 16'h0000;
				tick_q <= 1'b0;
			end else if (CE) begin
				tick_q <= (baud_cnt_q == 16'h0000);
				if (baud_cnt_q == 16'h0000) begin
					baud_cnt_q <= baud_div(
						field[link_station_pkg::FMT_BAUD_LSB +: 3]);
				end else begin
					baud_cnt_q <= baud_cnt_q - 16'h0001;
				end
			end
		end
		assign BAUD_TICK[p] = tick_q;

		// response: header, two station digits, ok mark, check code, CR
		always_comb begin
			case (idx_q)
				3'h0: next_char = hdr_q;
				3'h1: next_char = ch_hi_q;
				3'h2: next_char = ch_lo_q;
				3'h3: next_char = link_station_pkg::CH_OK;
				3'h4: next_char = hex_char(bcc_q[7:4]);
				3'h5: next_char = hex_char(bcc_q[3:0]);
				default: next_char = link_station_pkg::CH_CR;
			endcase
		end

		always_ff @(posedge REF_CLK or posedge RST) begin
			if (RST) begin
				state_q <= link_station_pkg::S_IDLE;
				hdr_q <= 8'h00;
				digit_hi_q <= 4'h0;
				ch_hi_q <= 8'h00;
				ch_lo_q <= 8'h00;
				bcc_q <= 8'h00;
				idx_q <= 3'h0;
				tx_q <= 8'h00;
				tx_valid_q <= 1'b0;
				tx_en_q <= 1'b0;
			end else if (CE) begin
				case (state_q)
					link_station_pkg::S_IDLE: begin
						tx_en_q <= 1'b0;
						if (RX_VALID[p] && field[link_station_pkg::FMT_LINK]
							&& (rx == link_station_pkg::CH_HDR_SHORT
							|| rx == link_station_pkg::CH_HDR_EXT)) begin
							hdr_q <= rx;
							state_q <= link_station_pkg::S_ST_HI;
						end
					end
					link_station_pkg::S_ST_HI: begin
						if (RX_VALID[p]) begin
							digit_hi_q <= rx[3:0];
							ch_hi_q <= rx;
							state_q <= rx_digit ? link_station_pkg::S_ST_LO
								: link_station_pkg::S_IDLE;
						end
					end
					link_station_pkg::S_ST_LO: begin
						if (RX_VALID[p]) begin
							ch_lo_q <= rx;
							// other stations drop the frame silently
							state_q <= (rx_digit
								&& rx_station == eff_station[p])
								? link_station_pkg::S_BODY
								: link_station_pkg::S_IDLE;
						end
					end
					link_station_pkg::S_BODY: begin
						if (RX_VALID[p] && rx == link_station_pkg::CH_CR) begin
							state_q <= link_station_pkg::S_SEND;
							idx_q <= 3'h0;
							bcc_q <= 8'h00;
							tx_en_q <= 1'b1;
						end
					end
					link_station_pkg::S_SEND: begin
						if (!tx_valid_q) begin
							tx_q <= next_char;
							tx_valid_q <= 1'b1;
							if (idx_q < 3'h4) begin
								bcc_q <= bcc_q ^ next_char;
							end
						end else if (TX_READY[p]) begin
							tx_valid_q <= 1'b0;
							idx_q <= idx_q + 3'h1;
							if (idx_q == link_station_pkg::RESP_LAST) begin
								state_q <= link_station_pkg::S_IDLE;
								tx_en_q <= 1'b0;
							end
						end
					end
					default: state_q <= link_station_pkg::S_IDLE;
				endcase
			end
		end

		assign TX_DATA[p * 8 +: 8] = tx_q;
		assign TX_VALID[p] = tx_valid_q;
		assign TX_EN[p] = tx_en_q;
	end

endmodule

// ### link_station_chk.sv
// port checker for the link station block
`timescale 1ns/100ps
module link_station_chk (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic [1:0] TX_READY,
	input wire logic [15:0] TX_DATA,
	input wire logic [1:0] TX_VALID,
	input wire logic [1:0] TX_EN,
	input wire logic [1:0] BAUD_TICK
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_bus_answer: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered next cycle");
	a_ack_once: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("bus answer lasted more than one cycle");
	a_hold_first: assert property (
		TX_VALID[0] && !TX_READY[0] |=> TX_VALID[0] && $stable(TX_DATA[7:0]))
		else $error("first port char dropped before acceptance");
	a_hold_second: assert property (
		TX_VALID[1] && !TX_READY[1] |=> TX_VALID[1] && $stable(TX_DATA[15:8]))
		else $error("second port char dropped before acceptance");
	a_head_first: assert property (
		$rose(TX_EN[0]) |=> TX_VALID[0] && TX_DATA[7:0] inside {8'h25, 8'h3c})
		else $error("first port response has no header");
	a_head_second: assert property (
		$rose(TX_EN[1]) |=> TX_VALID[1] && TX_DATA[15:8] inside {8'h25, 8'h3c})
		else $error("second port response has no header");
	a_valid_in_drive: assert property (
		(TX_VALID & ~TX_EN) == 2'b00)
		else $error("char offered with transmitter released");
	a_tick_pulse: assert property (
		BAUD_TICK[0] |=> !BAUD_TICK[0])
		else $error("baud tick longer than one cycle");
endmodule
bind link_station link_station_chk chk (.REF_CLK(REF_CLK), .RST(RST),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_READY(TX_READY),
	.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_EN(TX_EN),
	.BAUD_TICK(BAUD_TICK));

// ### link_host.sv
// host model: sends command frames, collects response characters
`timescale 1ns/100ps
module link_host #(
	parameter int GAP = 0
) (
	input wire logic clk,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_en,
	output logic tx_ready,
	input wire logic [3:0] stall
);
	logic [7:0] got[$];
	int wait_q = 0;
	int quiet_q = 0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	// ready drops after each char, returns stall+1 cycles later
	always @(posedge clk) begin
		quiet_q <= tx_en ? 0 : quiet_q + 1;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			tx_ready <= 1'b0;
			wait_q <= int'(stall);
		end else if (wait_q != 0) begin
			wait_q <= wait_q - 1;
		end else begin
			tx_ready <= 1'b1;
		end
	end
	task automatic send_char(input logic [7:0] c);
		@(posedge clk);
		rx_data <= c;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		// released line must not show a stale char
		rx_data <= ~c;
	endtask
	task automatic send_frame(input logic [7:0] hdr, input int st);
		int n = 0;
		while (quiet_q < GAP && n < 20000) begin
			@(posedge clk);
			n++;
		end
		send_char(hdr);
		send_char(8'h30 + 8'(st / 10));
		send_char(8'h30 + 8'(st % 10));
		send_char(8'h52);
		send_char(8'h0d);
	endtask
endmodule

// ### tb_top.sv
// self-checking bench for the link station block
`timescale 1ns/100ps
module tb_top;
	localparam int unsigned HZ = 2304000;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
	logic REF_CLK, RST, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic [7:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
	logic [3:0] AVS_BYTEENABLE, STATION_DIAL, PARITY_SEL, stall0, stall1;
	logic STATION_HIGH, DIFF_RATE_SW;
	logic [15:0] TX_DATA;
	wire [15:0] RX_DATA;
	wire [1:0] RX_VALID, TX_READY;
	logic [1:0] TX_VALID, TX_EN, BAUD_TICK, DATA_8BIT, STOP_2BIT;
	logic [6:0] TOOL_STATION;
	int fails = 0;
	int checks_done = 0;
	int rate[8] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200, 9600};
	row_t rows[10] = '{'{8'h00, 32'h05, 32'h05}, '{8'h00, 32'h00, 32'h05},
		'{8'h00, 32'h64, 32'h05}, '{8'h00, 32'h63, 32'h63},
		'{8'h04, 32'h2a, 32'h2a}, '{8'h08, 32'h07, 32'h07},
		'{8'h0c, 32'hec81, 32'hec81}, '{8'h0c, 32'h2d83, 32'hec83},
		'{8'h14, 32'hff, 32'h00}, '{8'h10, 32'h00, 32'h2a63}};
	link_station #(.CLK_HZ(HZ)) dut (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .STATION_DIAL(STATION_DIAL),
		.STATION_HIGH(STATION_HIGH), .DIFF_RATE_SW(DIFF_RATE_SW),
		.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_READY(TX_READY),
		.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_EN(TX_EN),
		.BAUD_TICK(BAUD_TICK), .DATA_8BIT(DATA_8BIT),
		.PARITY_SEL(PARITY_SEL), .STOP_2BIT(STOP_2BIT),
		.TOOL_STATION(TOOL_STATION));
	link_host #(.GAP(0)) host0 (.clk(REF_CLK), .rx_data(RX_DATA[7:0]),
		.rx_valid(RX_VALID[0]), .tx_data(TX_DATA[7:0]),
		.tx_valid(TX_VALID[0]), .tx_en(TX_EN[0]),
		.tx_ready(TX_READY[0]), .stall(stall0));
	// 200 us turnaround at 115200 on the differential port
	link_host #(.GAP(5000)) host1 (.clk(REF_CLK), .rx_data(RX_DATA[15:8]),
		.rx_valid(RX_VALID[1]), .tx_data(TX_DATA[15:8]),
		.tx_valid(TX_VALID[1]), .tx_en(TX_EN[1]),
		.tx_ready(TX_READY[1]), .stall(stall1));
	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (AVS_WAITREQUEST !== 1'b0) begin
			fails++;
			wrap_up;
		end
	endtask
	task automatic next_tick(input int p, output int g);
		g = 0;
		do begin
			@(posedge REF_CLK);
			g++;
		end while (BAUD_TICK[p] !== 1'b1 && g < 2000);
		if (g >= 2000) begin
			fails++;
			wrap_up;
		end
	endtask
	function automatic logic [7:0] hexc(input logic [3:0] v);
		return v < 4'ha ? 8'h30 + v : 8'h37 + v;
	endfunction
	task automatic frame(input bit p, input logic [7:0] h, input int st,
		input bit ok);
		logic [7:0] e[7];
		logic [7:0] q[$];
		logic [7:0] x;
		e = '{h, 8'h30 + 8'(st / 10), 8'h30 + 8'(st % 10), 8'h24, 8'h00,
			8'h00, 8'h0d};
		x = e[0] ^ e[1] ^ e[2] ^ e[3];
		e[4] = hexc(x[7:4]);
		e[5] = hexc(x[3:0]);
		if (p) host1.send_frame(h, st);
		else host0.send_frame(h, st);
		for (int n = 0; n < 300 && q.size() < 7; n++) begin
			@(posedge REF_CLK);
			if (p) q = host1.got;
			else q = host0.got;
		end
		repeat (3) @(posedge REF_CLK);
		chk(32'(q.size()), ok ? 32'h7 : 32'h0);
		if (ok && q.size() < 7) wrap_up;
		for (int i = 0; i < 7 && ok; i++) chk(q[i], e[i]);
		chk({30'h0, TX_EN}, 32'h0);
		host0.got.delete();
		host1.got.delete();
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int g;
		RST = 1'b1;
		CE = 1'b1;
		AVS_ADDRESS = 8'h00;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hf;
		STATION_DIAL = 4'h0;
		STATION_HIGH = 1'b0;
		DIFF_RATE_SW = 1'b1;
		stall0 = 4'h3;
		stall1 = 4'h2;
		repeat (8) @(posedge REF_CLK);
		RST <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			bus(0, 8'(4 * i), 32'h0);
			chk(rd, 32'h1);
		end
		bus(0, 8'h0c, 32'h0);
		chk(rd, 32'ha3a3);
		chk({DATA_8BIT, STOP_2BIT, PARITY_SEL}, 32'hc5);
		foreach (rows[i]) begin
			bus(1, rows[i].a, rows[i].w);
			bus(0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
		end
		chk({DATA_8BIT, STOP_2BIT, PARITY_SEL}, 32'h69);
		for (int i = 0; i < 8; i++) begin
			bus(1, 8'h0c, {16'h0, 8'hec, 8'h81 | 8'(i << 4)});
			repeat (3) next_tick(0, g);
			chk(g, HZ / rate[i]);
		end
		// second port kept at 115200 through the sweep
		repeat (3) next_tick(1, g);
		chk(g, HZ / rate[6]);
		frame(0, 8'h25, 99, 1);
		frame(1, 8'h3c, 42, 1);
		frame(0, 8'h3c, 5, 0);
		bus(1, 8'h0c, 32'hec71);
		frame(0, 8'h25, 99, 0);
		bus(1, 8'h0c, 32'hec81);
		STATION_DIAL <= 4'h5;
		DIFF_RATE_SW <= 1'b0;
		repeat (8) @(posedge REF_CLK);
		bus(0, 8'h10, 32'h0);
		chk(rd, 32'h30505);
		STATION_DIAL <= 4'h3;
		STATION_HIGH <= 1'b1;
		repeat (8) @(posedge REF_CLK);
		bus(0, 8'h10, 32'h0);
		chk(rd, 32'h31313);
		frame(1, 8'h25, 19, 1);
		frame(0, 8'h25, 99, 0);
		chk({25'h0, TOOL_STATION}, 32'h7);
		RST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		bus(0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		wrap_up;
	end
endmodule
